//--- hdl/pwm_timer.sv
// Purpose: 8-bit timer with normal, clear-on-match and fast pwm modes
// Assumes: tick_i is the prescaled timer clock enable, one cycle wide
// Notes:   phase correct modes are not built; other codes count up
`timescale 1ns/100ps
`include "tmr_defines.svh"

// Contract
// - nonzero action: compare state overrides port value
// - pin direction bit still gates the pin
// - reset clears both compare output states
// - override depends on action field only
// - action zero leaves state unchanged on match
// - new action used from next match
// - non-pwm force strobe applies action now
// - only mode field picks count sequence
// - mode 0 counts up, wraps ff to 00
// - mode 0 overflow set when counter wraps
// - mode 0 counter writable any time
// - mode 2 clears counter at compare a
// - mode 2 compare a unbuffered, may wrap
// - mode 2 compare flag a at top
// - mode 2 action 1 toggles output a
// - mode 2 overflow on max to zero
// - modes 3,7 count to top then clear
// - fast pwm: 2 clear/set, 3 set/clear
// - fast pwm overflow set at top
// - fast pwm toggle only a, bit2 set
// - compare extremes: spike or constant output
// - fast pwm compare values double buffered
// - match sets flag next tick, write-one clears
// - counter write blocks next tick's matches
// - clock select zero stops, write wins
// - non-pwm: 01 toggle, 10 clear, 11 set
module pwm_timer (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // timer clock enable from prescaler
    input  wire logic             tick_i,
    // register bus
    input  wire tmr_pkg::wb_req_t wb_req_i,
    output tmr_pkg::wb_rsp_t      wb_rsp_o,
    // compare output pins
    output tmr_pkg::pin_t         pin_o
);
    import tmr_pkg::*;

    // ==========================================================
    // state and decode signals
    tmr_state_t st_q;       // registered state
    tmr_state_t st_d;       // next state
    logic       tick;       // timer clock, gated by clock select
    logic       pwm;        // fast pwm mode active
    logic [7:0] top;        // top of count
    logic       at_top;     // counter sits at top
    logic       match_a;    // unblocked equality, channel a
    logic       match_b;    // unblocked equality, channel b
    logic       bottom;     // fast pwm clear to bottom this tick
    logic       ovf_set;    // overflow event this cycle, beats a clear
    logic       req;        // bus request present, still high in its ack cycle
    logic       wr;         // write takes effect this edge
    logic       wr_cnt;     // software write of the counter
    logic       foc_a;      // force strobe a accepted
    logic       foc_b;      // force strobe b accepted

    // ==========================================================
    // next compare output state for one channel
    function automatic logic next_ocs(input logic       cur,
                                      input logic [1:0] com,
                                      input logic       hit,
                                      input logic       bot,
                                      input logic       fast,
                                      input logic       tgl_ok);
        logic r;
        r = cur;
        if (!fast) begin
            // non-pwm: action codes on match
            if (hit) begin
                case (com)
                    `TMR_ACT_TOGGLE: r = ~cur;
                    `TMR_ACT_CLEAR:  r = 1'b0;
                    `TMR_ACT_SET:    r = 1'b1;
                    default:         r = cur;
                endcase
            end
        end else if (com == `TMR_ACT_TOGGLE) begin
            // toggle only where allowed
            if (hit && tgl_ok) begin
                r = ~cur;
            end
        end else if (com[1]) begin
            // bottom beats a match at top, so compare at max is flat
            if (bot) begin
                r = ~com[0];
            end else if (hit) begin
                r = com[0];
            end
        end
        return r;
    endfunction : next_ocs

    // ==========================================================
    // mode decode and comparators
    always_comb begin
        tick    = tick_i && (st_q.cs != `TMR_CS_STOP);
        pwm     = (st_q.wgm == WM_FAST) || (st_q.wgm == WM_FASTA);
        top     = (st_q.wgm == WM_FASTA) ? st_q.effa : `TMR_MAX;
        at_top  = (st_q.cnt == top);
        match_a = (st_q.cnt == st_q.effa) && !st_q.blk;
        match_b = (st_q.cnt == st_q.effb) && !st_q.blk;
        bottom  = tick && pwm && at_top;
        ovf_set = tick && (pwm ? at_top : (st_q.cnt == `TMR_MAX));
    end

    // ==========================================================
    // bus decode: answer one cycle after the request, write then
    always_comb begin
        req    = wb_req_i.cyc && wb_req_i.stb;
        wr     = req && wb_req_i.we && st_q.ack;
        wr_cnt = wr && (wb_req_i.adr == `TMR_OFS_COUNT) && wb_req_i.sel[0];
        foc_a  = wr && (wb_req_i.adr == `TMR_OFS_CTRL) && wb_req_i.sel[2]
                 && wb_req_i.dat[`TMR_CTRL_FOCA_BIT] && !pwm;
        foc_b  = wr && (wb_req_i.adr == `TMR_OFS_CTRL) && wb_req_i.sel[2]
                 && wb_req_i.dat[`TMR_CTRL_FOCB_BIT] && !pwm;
    end

    // ==========================================================
    // next state
    always_comb begin
        st_d = st_q;
        // counting, held without a tick
        if (tick) begin
            st_d.blk = 1'b0;
            if (pwm) begin
                st_d.cnt = at_top ? `TMR_BOTTOM : st_q.cnt + 8'h01;
                if (at_top) begin
                    st_d.ovf  = 1'b1;
                    st_d.effa = st_q.bufa;
                    st_d.effb = st_q.bufb;
                end
            end else if (st_q.wgm == WM_CTC) begin
                // unbuffered top: a top below count wraps through max
                st_d.cnt = match_a ? `TMR_BOTTOM : st_q.cnt + 8'h01;
                if (st_q.cnt == `TMR_MAX) begin
                    st_d.ovf = 1'b1;
                end
            end else begin
                st_d.cnt = st_q.cnt + 8'h01;
                if (st_q.cnt == `TMR_MAX) begin
                    st_d.ovf = 1'b1;
                end
            end
            // flags on the tick after equality
            if (match_a) begin
                st_d.ocfa = 1'b1;
            end
            if (match_b) begin
                st_d.ocfb = 1'b1;
            end
            // waveform, action read at the match itself
            st_d.ocsa = next_ocs(st_q.ocsa, st_q.coma, match_a, bottom, pwm,
                                 st_q.wgm[2]);
            st_d.ocsb = next_ocs(st_q.ocsb, st_q.comb, match_b, bottom, pwm,
                                 1'b0);
        end
        // force strobes act as a match without flags or clear
        if (foc_a) begin
            st_d.ocsa = next_ocs(st_d.ocsa, st_q.coma, 1'b1, 1'b0, 1'b0, 1'b0);
        end
        if (foc_b) begin
            st_d.ocsb = next_ocs(st_d.ocsb, st_q.comb, 1'b1, 1'b0, 1'b0, 1'b0);
        end
        // register writes
        if (wr) begin
            case (wb_req_i.adr)
                `TMR_OFS_CTRL: begin
                    if (wb_req_i.sel[0]) begin
                        st_d.wgm  = wb_req_i.dat[`TMR_CTRL_WGM_MSB:`TMR_CTRL_WGM_LSB];
                        st_d.comb = wb_req_i.dat[`TMR_CTRL_COMB_MSB:`TMR_CTRL_COMB_LSB];
                        st_d.coma = wb_req_i.dat[`TMR_CTRL_COMA_MSB:`TMR_CTRL_COMA_LSB];
                    end
                    if (wb_req_i.sel[1]) begin
                        st_d.cs = wb_req_i.dat[`TMR_CTRL_CS_MSB:`TMR_CTRL_CS_LSB];
                    end
                end
                `TMR_OFS_COUNT: begin
                    // write beats count and clear, any mode, any time
                    if (wb_req_i.sel[0]) begin
                        st_d.cnt = wb_req_i.dat[7:0];
                        st_d.blk = 1'b1;
                    end
                end
                `TMR_OFS_CMPA: begin
                    if (wb_req_i.sel[0]) begin
                        st_d.bufa = wb_req_i.dat[7:0];
                        if (!pwm) begin
                            st_d.effa = wb_req_i.dat[7:0];
                        end
                    end
                end
                `TMR_OFS_CMPB: begin
                    if (wb_req_i.sel[0]) begin
                        st_d.bufb = wb_req_i.dat[7:0];
                        if (!pwm) begin
                            st_d.effb = wb_req_i.dat[7:0];
                        end
                    end
                end
                `TMR_OFS_FLAGS: begin
                    // write one clears, a set in this cycle wins
                    if (wb_req_i.sel[0]) begin
                        st_d.ovf  = st_d.ovf && !(wb_req_i.dat[`TMR_FLG_OVF_BIT]
                                    && !ovf_set);
                        st_d.ocfa = st_d.ocfa && !(wb_req_i.dat[`TMR_FLG_CMPA_BIT]
                                    && !(tick && match_a));
                        st_d.ocfb = st_d.ocfb && !(wb_req_i.dat[`TMR_FLG_CMPB_BIT]
                                    && !(tick && match_b));
                    end
                end
                `TMR_OFS_PORT: begin
                    if (wb_req_i.sel[0]) begin
                        st_d.pval = {wb_req_i.dat[`TMR_PORT_VALB_BIT],
                                     wb_req_i.dat[`TMR_PORT_VALA_BIT]};
                        st_d.pdir = {wb_req_i.dat[`TMR_PORT_DIRB_BIT],
                                     wb_req_i.dat[`TMR_PORT_DIRA_BIT]};
                    end
                end
                default: begin
                    // unmapped: answered, nothing stored
                end
            endcase
        end
        // bus answer and read data, ack drops after one cycle
        st_d.ack  = req && !st_q.ack;
        st_d.rdat = `TMR_RD_ZERO;
        if (req && !st_q.ack) begin
            case (wb_req_i.adr)
                `TMR_OFS_CTRL: begin
                    st_d.rdat[`TMR_CTRL_WGM_MSB:`TMR_CTRL_WGM_LSB]   = st_q.wgm;
                    st_d.rdat[`TMR_CTRL_COMB_MSB:`TMR_CTRL_COMB_LSB] = st_q.comb;
                    st_d.rdat[`TMR_CTRL_COMA_MSB:`TMR_CTRL_COMA_LSB] = st_q.coma;
                    st_d.rdat[`TMR_CTRL_CS_MSB:`TMR_CTRL_CS_LSB]     = st_q.cs;
                end
                `TMR_OFS_COUNT: st_d.rdat[7:0] = st_q.cnt;
                `TMR_OFS_CMPA:  st_d.rdat[7:0] = st_q.bufa;
                `TMR_OFS_CMPB:  st_d.rdat[7:0] = st_q.bufb;
                `TMR_OFS_FLAGS: begin
                    st_d.rdat[`TMR_FLG_OVF_BIT]  = st_q.ovf;
                    st_d.rdat[`TMR_FLG_CMPA_BIT] = st_q.ocfa;
                    st_d.rdat[`TMR_FLG_CMPB_BIT] = st_q.ocfb;
                end
                `TMR_OFS_PORT: begin
                    st_d.rdat[`TMR_PORT_VALA_BIT] = st_q.pval[0];
                    st_d.rdat[`TMR_PORT_VALB_BIT] = st_q.pval[1];
                    st_d.rdat[`TMR_PORT_DIRA_BIT] = st_q.pdir[0];
                    st_d.rdat[`TMR_PORT_DIRB_BIT] = st_q.pdir[1];
                    st_d.rdat[`TMR_PORT_OCSA_BIT] = st_q.ocsa;
                    st_d.rdat[`TMR_PORT_OCSB_BIT] = st_q.ocsb;
                end
                default: st_d.rdat = `TMR_RD_ZERO;
            endcase
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // outputs: override follows action field only, never mode
    always_comb begin
        wb_rsp_o.ack = st_q.ack;
        wb_rsp_o.dat = st_q.rdat;
        pin_o.out_a  = (st_q.coma != `TMR_ACT_OFF) ? st_q.ocsa : st_q.pval[0];
        pin_o.out_b  = (st_q.comb != `TMR_ACT_OFF) ? st_q.ocsb : st_q.pval[1];
        pin_o.oe_a   = st_q.pdir[0];
        pin_o.oe_b   = st_q.pdir[1];
    end

    // ==========================================================
    // checks
    sequence s_cnt_write;
        wr_cnt;
    endsequence

    property p_reset_clear;
        @(posedge clk_i) rst_i |=> (!st_q.ocsa && !st_q.ocsb);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("state not cleared");

    property p_pin_a;
        @(posedge clk_i) disable iff (rst_i)
        (st_q.coma != `TMR_ACT_OFF) |-> (pin_o.out_a == st_q.ocsa && pin_o.oe_a == st_q.pdir[0]);
    endproperty
    a_pin_a: assert property (p_pin_a) else $error("pin a override wrong");

    property p_wrap;
        @(posedge clk_i) disable iff (rst_i)
        (tick && st_q.wgm == WM_NORMAL && st_q.cnt == `TMR_MAX && !wr_cnt)
        |=> (st_q.cnt == `TMR_BOTTOM && st_q.ovf);
    endproperty
    a_wrap: assert property (p_wrap) else $error("mode 0 wrap wrong");

    property p_ctc_clear;
        @(posedge clk_i) disable iff (rst_i)
        (tick && st_q.wgm == WM_CTC && match_a && !wr_cnt)
        |=> (st_q.cnt == `TMR_BOTTOM && st_q.ocfa);
    endproperty
    a_ctc_clear: assert property (p_ctc_clear) else $error("ctc clear wrong");

    property p_fast_top;
        @(posedge clk_i) disable iff (rst_i)
        (tick && pwm && at_top && !wr_cnt) |=> (st_q.cnt == `TMR_BOTTOM && st_q.ovf);
    endproperty
    a_fast_top: assert property (p_fast_top) else $error("fast top wrong");

    property p_block;
        @(posedge clk_i) disable iff (rst_i)
        s_cnt_write |=> (!match_a && !match_b);
    endproperty
    a_block: assert property (p_block) else $error("match not blocked");

    property p_hold;
        @(posedge clk_i) disable iff (rst_i)
        (!tick && !wr) |=> ($stable(st_q.cnt) && $stable(st_q.ocsa) && $stable(st_q.ocfa));
    endproperty
    a_hold: assert property (p_hold) else $error("state moved without tick");

    property p_force_clear;
        @(posedge clk_i) disable iff (rst_i)
        (foc_a && !tick && st_q.coma == `TMR_ACT_CLEAR) |=> !st_q.ocsa;
    endproperty
    a_force_clear: assert property (p_force_clear) else $error("force ignored");

    property p_buffered;
        @(posedge clk_i) disable iff (rst_i)
        (pwm && !tick && wr && wb_req_i.adr == `TMR_OFS_CMPA) |=> $stable(st_q.effa);
    endproperty
    a_buffered: assert property (p_buffered) else $error("compare not buffered");

    property p_ovf_set;
        @(posedge clk_i) disable iff (rst_i)
        ovf_set |=> st_q.ovf;
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow set lost");

    property p_flag_b;
        @(posedge clk_i) disable iff (rst_i)
        (tick && match_b) |=> st_q.ocfb;
    endproperty
    a_flag_b: assert property (p_flag_b) else $error("compare flag b not set");

    property p_bottom_set;
        @(posedge clk_i) disable iff (rst_i)
        (bottom && st_q.coma == `TMR_ACT_CLEAR) |=> st_q.ocsa;
    endproperty
    a_bottom_set: assert property (p_bottom_set) else $error("bottom set missing");

    property p_match_clear;
        @(posedge clk_i) disable iff (rst_i)
        (tick && pwm && match_a && !at_top && st_q.coma == `TMR_ACT_CLEAR) |=> !st_q.ocsa;
    endproperty
    a_match_clear: assert property (p_match_clear) else $error("match clear missing");

    property p_pin_b;
        @(posedge clk_i) disable iff (rst_i)
        (st_q.comb != `TMR_ACT_OFF)
        |-> (pin_o.out_b == st_q.ocsb && pin_o.oe_b == st_q.pdir[1]);
    endproperty
    a_pin_b: assert property (p_pin_b) else $error("pin b override wrong");

endmodule : pwm_timer

//--- hdl/tmr_defines.svh
// Purpose: named constants for the compare/waveform timer block
// Assumes: 32-bit classic Wishbone register port, byte addressed
// Notes:   definitions only
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH

// ==========================================================
// register byte offsets
`define TMR_OFS_CTRL     8'h00
`define TMR_OFS_COUNT    8'h04
`define TMR_OFS_CMPA     8'h08
`define TMR_OFS_CMPB     8'h0C
`define TMR_OFS_FLAGS    8'h10
`define TMR_OFS_PORT     8'h14

// ==========================================================
// control register fields
`define TMR_CTRL_WGM_LSB   0
`define TMR_CTRL_WGM_MSB   2
`define TMR_CTRL_COMB_LSB  4
`define TMR_CTRL_COMB_MSB  5
`define TMR_CTRL_COMA_LSB  6
`define TMR_CTRL_COMA_MSB  7
`define TMR_CTRL_CS_LSB    8
`define TMR_CTRL_CS_MSB    10
`define TMR_CTRL_FOCA_BIT  16
`define TMR_CTRL_FOCB_BIT  17

// ==========================================================
// flag and port register fields
`define TMR_FLG_OVF_BIT    0
`define TMR_FLG_CMPA_BIT   1
`define TMR_FLG_CMPB_BIT   2
`define TMR_PORT_VALA_BIT  0
`define TMR_PORT_VALB_BIT  1
`define TMR_PORT_DIRA_BIT  2
`define TMR_PORT_DIRB_BIT  3
`define TMR_PORT_OCSA_BIT  8
`define TMR_PORT_OCSB_BIT  9

// ==========================================================
// counter values and action codes
`define TMR_BOTTOM      8'h00
`define TMR_MAX         8'hFF
`define TMR_CS_STOP     3'h0
`define TMR_ACT_OFF     2'h0
`define TMR_ACT_TOGGLE  2'h1
`define TMR_ACT_CLEAR   2'h2
`define TMR_ACT_SET     2'h3
`define TMR_RD_ZERO     32'h0000_0000

`endif

//--- hdl/tmr_pkg.sv
// Purpose: types for the compare/waveform timer block
// Assumes: classic Wishbone request/response carried as structs
// Notes:   constants live in tmr_defines.svh
package tmr_pkg;

    // ==========================================================
    // waveform modes that the counter knows
    typedef enum logic [2:0] {
        WM_NORMAL = 3'h0,   // free-running up count
        WM_CTC    = 3'h2,   // clear on compare A
        WM_FAST   = 3'h3,   // fast pwm, top at max
        WM_FASTA  = 3'h7    // fast pwm, top at compare A
    } wave_mode_t;

    // ==========================================================
    // bus carriers
    typedef struct packed {
        logic        cyc;   // cycle valid
        logic        stb;   // strobe
        logic        we;    // write enable
        logic [7:0]  adr;   // byte address
        logic [3:0]  sel;   // byte lanes
        logic [31:0] dat;   // write data
    } wb_req_t;

    typedef struct packed {
        logic        ack;   // answer
        logic [31:0] dat;   // read data
    } wb_rsp_t;

    // compare output pins, three-signal form minus input
    typedef struct packed {
        logic out_a;        // level for pin a
        logic oe_a;         // pin a driven
        logic out_b;        // level for pin b
        logic oe_b;         // pin b driven
    } pin_t;

    // ==========================================================
    // whole module state
    typedef struct packed {
        logic [7:0]  cnt;   // counter_value
        logic [7:0]  bufa;  // software copy of compare_value_a
        logic [7:0]  bufb;  // software copy of compare value b
        logic [7:0]  effa;  // compare_value_a in effect
        logic [7:0]  effb;  // compare value b in effect
        logic        ocsa;  // compare_output_a state
        logic        ocsb;  // compare_output_b state
        logic        ovf;   // overflow_flag
        logic        ocfa;  // compare_flag_a
        logic        ocfb;  // compare flag b
        logic        blk;   // match block after counter write
        logic [2:0]  wgm;   // waveform_mode_field
        logic [1:0]  coma;  // compare_output_action_a
        logic [1:0]  comb;  // compare output action b
        logic [2:0]  cs;    // clock_select_field
        logic [1:0]  pval;  // ordinary port values b,a
        logic [1:0]  pdir;  // pin_direction_bit b,a
        logic        ack;   // bus answer
        logic [31:0] rdat;  // read data
    } tmr_state_t;

endpackage : tmr_pkg

//--- verif/pin_load.sv
// Purpose: external load on the two compare output pins
// Assumes: pins carry level plus drive enable
// Notes:   weak pull-down, so an undriven pin never shows a stale level
`timescale 1ns/100ps
module pin_load (
    // pins from the timer
    input  wire tmr_pkg::pin_t pin_i,
    // resolved wire levels
    output logic               level_a_o,
    output logic               level_b_o
);
    // ==========================================================
    // resolution: the pin shows a level only while driven
    assign level_a_o = pin_i.oe_a ? pin_i.out_a : 1'b0;
    assign level_b_o = pin_i.oe_b ? pin_i.out_b : 1'b0;
endmodule : pin_load

//--- verif/pwm_timer_tb_top.sv
// Purpose: self-checking bench for the compare/waveform timer
// Assumes: classic Wishbone register port, ack one cycle after request
// Notes:   random compare tops come from a fixed-start lfsr
`timescale 1ns/100ps
`include "tmr_defines.svh"
module pwm_timer_tb_top;
    import tmr_pkg::*;
    logic            clk_i = 1'b0;  // 250 MHz
    logic            rst_i = 1'b1;  // sync reset
    logic            tick_i = 1'b0; // timer enable
    wb_req_t         req = '0;      // bus request
    wb_rsp_t         rsp;           // bus answer
    pin_t            pins;          // pins to the load
    logic            lva, lvb;      // wire levels
    logic [31:0]     q;             // read data
    logic [7:0]      r = 8'h41;     // lfsr state, starts at 65
    logic            s = 1'b0;      // expected state a
    int              n_mismatch = 0;
    int              cmp_count = 0;
    always #2 clk_i = ~clk_i;
    pwm_timer dut (.clk_i(clk_i), .rst_i(rst_i), .tick_i(tick_i),
                   .wb_req_i(req), .wb_rsp_o(rsp), .pin_o(pins));
    pin_load load (.pin_i(pins), .level_a_o(lva), .level_b_o(lvb));
    // ==========================================================
    // helpers
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr
    // next compare state for a non-pwm match action
    function automatic logic act(input logic [1:0] c, input logic st);
        act = (c == 2'h1) ? ~st : (c == 2'h2) ? 1'b0 : (c == 2'h3) ? 1'b1 : st;
    endfunction : act
    function automatic logic [31:0] ctl(input logic [2:0] m, input logic [1:0] a,
                                        input logic [2:0] cs, input logic f);
        ctl = {15'h0000, f, 5'h00, cs, a, 2'h0, 1'b0, m};
    endfunction : ctl
    task automatic end_sim;
        if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one classic cycle; holds request until ack, then one idle cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
        @(posedge clk_i);
        while (rsp.ack !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        q = rsp.dat;
        req <= '0;
        if (n == 20) begin
            n_mismatch++;
            end_sim();
        end
        @(posedge clk_i);
    endtask : wb
    task automatic tk(input int n);
        repeat (n) begin
            tick_i <= 1'b1;
            @(posedge clk_i);
        end
        tick_i <= 1'b0;
        @(posedge clk_i);
    endtask : tk
    // ==========================================================
    // main sequence
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, `TMR_OFS_PORT, '0);
        chk("port", 32'h0000_0000, q);
        wb(1'b1, `TMR_OFS_PORT, 32'h0000_0004);
        // every action code forced twice while stopped in mode 0
        for (int i = 0; i < 8; i++) begin
            wb(1'b1, `TMR_OFS_CTRL, ctl(3'h0, i[2:1], 3'h0, 1'b0));
            wb(1'b1, `TMR_OFS_CTRL, ctl(3'h0, i[2:1], 3'h0, 1'b1));
            s = act(i[2:1], s);
            wb(1'b0, `TMR_OFS_PORT, '0);
            chk("state_a", {31'h0, s}, {31'h0, q[`TMR_PORT_OCSA_BIT]});
            chk("pin_a", {31'h0, (i[2:1] != 2'h0) & s}, {31'h0, lva});
        end
        // stopped clock: ticks ignored, write still lands
        wb(1'b1, `TMR_OFS_COUNT, 32'h0000_0033);
        tk(5);
        wb(1'b0, `TMR_OFS_COUNT, '0);
        chk("count_stop", 32'h0000_0033, q);
        // mode 0 wrap with port value shown on the pin
        wb(1'b1, `TMR_OFS_PORT, 32'h0000_0005);
        wb(1'b1, `TMR_OFS_CTRL, ctl(3'h0, 2'h0, 3'h1, 1'b0));
        wb(1'b1, `TMR_OFS_COUNT, 32'h0000_00FD);
        wb(1'b1, `TMR_OFS_FLAGS, 32'h0000_0007);
        tk(3);
        wb(1'b0, `TMR_OFS_COUNT, '0);
        chk("count_wrap", 32'h0000_0000, q);
        wb(1'b0, `TMR_OFS_FLAGS, '0);
        chk("flags_ovf", 32'h0000_0001, q);
        chk("pin_port", 32'h0000_0001, {31'h0, lva});
        // clear-on-match with random tops, toggling output a
        for (int k = 0; k < 4; k++) begin
            r = lfsr(r);
            wb(1'b1, `TMR_OFS_CTRL, ctl(3'h2, 2'h1, 3'h1, 1'b0));
            wb(1'b1, `TMR_OFS_CMPA, {27'h0, r[4:0] | 5'h01});
            wb(1'b1, `TMR_OFS_COUNT, 32'h0000_0000);
            wb(1'b1, `TMR_OFS_FLAGS, 32'h0000_0007);
            tk(int'(r[4:0] | 5'h01) + 1);
            s = ~s;
            wb(1'b0, `TMR_OFS_COUNT, '0);
            chk("ctc_count", 32'h0000_0000, q);
            wb(1'b0, `TMR_OFS_FLAGS, '0);
            chk("ctc_flags", 32'h0000_0002, q);
            chk("ctc_pin", {31'h0, s}, {31'h0, lva});
        end
        // fast pwm, top at max, non-inverting
        wb(1'b1, `TMR_OFS_CTRL, ctl(3'h0, 2'h0, 3'h0, 1'b0));
        wb(1'b1, `TMR_OFS_CMPA, 32'h0000_0080);
        wb(1'b1, `TMR_OFS_CTRL, ctl(3'h3, 2'h2, 3'h1, 1'b0));
        wb(1'b1, `TMR_OFS_COUNT, 32'h0000_00FE);
        wb(1'b1, `TMR_OFS_FLAGS, 32'h0000_0007);
        tk(2);
        wb(1'b0, `TMR_OFS_FLAGS, '0);
        chk("pwm_ovf", 32'h0000_0001, q & 32'h0000_0001);
        chk("pwm_set", 32'h0000_0001, {31'h0, lva});
        tk(8'h81);
        chk("pwm_clr", 32'h0000_0000, {31'h0, lva});
        // fast pwm, top at compare a, channel b inverting on pin b
        wb(1'b1, `TMR_OFS_CTRL, ctl(3'h0, 2'h0, 3'h0, 1'b0));
        wb(1'b1, `TMR_OFS_CMPA, 32'h0000_0010);
        wb(1'b1, `TMR_OFS_CMPB, 32'h0000_0008);
        wb(1'b1, `TMR_OFS_PORT, 32'h0000_000C);
        wb(1'b1, `TMR_OFS_CTRL, ctl(3'h7, 2'h2, 3'h1, 1'b0) | 32'h0000_0030);
        wb(1'b1, `TMR_OFS_COUNT, 32'h0000_0000);
        wb(1'b1, `TMR_OFS_FLAGS, 32'h0000_0007);
        tk(9);
        wb(1'b0, `TMR_OFS_COUNT, '0);
        chk("top_cnt", 32'h0000_0009, q);
        chk("pins_mid", 32'h0000_0002, {30'h0, lvb, lva});
        tk(8);
        wb(1'b0, `TMR_OFS_COUNT, '0);
        chk("top_wrap", 32'h0000_0000, q);
        wb(1'b0, `TMR_OFS_FLAGS, '0);
        chk("top_flags", 32'h0000_0007, q);
        chk("pins_bottom", 32'h0000_0001, {30'h0, lvb, lva});
        wb(1'b1, `TMR_OFS_FLAGS, 32'h0000_0002);
        wb(1'b0, `TMR_OFS_FLAGS, '0);
        chk("flag_clear", 32'h0000_0005, q);
        // second reset mid-run clears the compare states
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, `TMR_OFS_PORT, '0);
        chk("port_reset", 32'h0000_0000, q);
        end_sim();
    end
endmodule : pwm_timer_tb_top
